// ==== pkg/regport_pkg.sv ====
package regport_pkg;
  localparam logic [6:0] slave_addr = 7'h60;
  localparam logic [4:0] master_code_top = 5'h01;
  localparam logic [7:0] reg_level_low = 8'h00;
  localparam logic [7:0] reg_level_high = 8'h01;
  localparam logic [7:0] reg_control = 8'h02;
  localparam logic [7:0] reg_vendor = 8'h03;
  localparam logic [7:0] reg_revision = 8'h04;
  localparam logic [7:0] reg_status = 8'h05;
  localparam logic [7:0] level_low_default = 8'h00;
  localparam logic [7:0] level_high_default = 8'h80;
  localparam logic [7:0] control_default = 8'h00;
  localparam logic [7:0] control_write_mask = 8'hf0;
  localparam int reset_bit = 2;
  localparam int enable_bit = 7;
  localparam int good_bit = 7;
  localparam int data_width = 8;
  localparam int fifo_depth = 16;
  localparam logic [2:0] last_bit = 3'h7;
  typedef enum {st_idle, st_addr, st_addr_ack, st_reg, st_reg_ack,
    st_wdata, st_wdata_ack, st_rdata, st_rdata_ack, st_ignore} state_t;
endpackage

// ==== hw/byte_fifo.sv ====
`timescale 1ns/1ps
module byte_fifo #(
  parameter int width = 8,
  parameter int depth = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [width-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [width-1:0] out_data_o
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw:0] wr_ptr;
  logic [aw:0] rd_ptr;
  logic [aw:0] next_wr_ptr;
  logic [aw:0] next_rd_ptr;
  logic push;
  logic pop;

  always_comb
  begin
    in_ready_o = (wr_ptr - rd_ptr) != (aw+1)'(depth);
    out_valid_o = wr_ptr != rd_ptr;
    out_data_o = mem[rd_ptr[aw-1:0]];
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    next_wr_ptr = flush_i ? '0 : wr_ptr + (aw+1)'(push);
    next_rd_ptr = flush_i ? '0 : rd_ptr + (aw+1)'(pop);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
    if (push)
      mem[wr_ptr[aw-1:0]] <= in_data_i;
  end
endmodule

// ==== hw/regulator_i2c_register_port.sv ====
`timescale 1ns/1ps
// Contract
// - scl only sampled; sda only pulled low, never driven high
// - sda pulled low only for read data bits and acknowledge
// - every byte moves msb first, bit seven leading
// - answer only to address 1100000 plus direction bit
// - sample sda on scl rise, change sda while scl low
// - bus idles with sda and scl high around transactions
// - sda fall with scl high starts a transfer
// - sda rise with scl high stops, port returns idle
// - read: register address, repeated start, address with read bit
// - master code byte is never acknowledged
// - repeated start after master code enters high speed
// - high speed lasts until stop; packets split by repeated start
// - acknowledge pulls sda low in ninth clock; nack leaves it high
// - register 00 setting for select low, 01 for select high
// - register 02 holds discharge enable and rising slew rate
// - registers 03 and 04 read-only identification
// - enable low holds defaults and silences the bus
// - reset bit restores defaults and reads zero
// - status top bit set when enabled, soft-start done and bit 7 of the selected level register set
module regulator_i2c_register_port
  import regport_pkg::*;
#(
  parameter logic [7:0] vendor_ident = 8'h5a, // arbitrary value
  parameter logic [7:0] revision_ident = 8'h03 // arbitrary value
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic enable_pin_i,
  input wire logic level_select_pin_i,
  input wire logic soft_start_done_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [7:0] active_setting_o,
  output logic discharge_enable_o,
  output logic [2:0] slew_rate_o,
  output logic high_speed_o,
  output logic write_valid_o,
  output logic [7:0] write_data_o
);
  logic [1:0] scl_sync, sda_sync, en_sync, sel_sync;
  logic scl_d, sda_d;
  state_t state, next_state;
  logic [7:0] shift, next_shift;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] reg_ptr, next_reg_ptr;
  logic [7:0] level_low, level_high, control;
  logic [7:0] next_level_low, next_level_high, next_control;
  logic hs_mode, next_hs_mode, hs_pending, next_hs_pending;
  logic skip_fall, next_skip_fall;
  logic next_sda_oe, next_write_valid;
  logic [7:0] next_setting, next_write_data;
  logic scl_rise, scl_fall, start_seen, stop_seen, en_ok;
  logic fifo_valid, fifo_ready, fifo_in_valid;
  logic [7:0] fifo_out, read_value, status_value;
  logic [7:0] write_ptr_q;
  logic [7:0] ptr_queue [fifo_depth];
  logic [3:0] pq_wr, pq_rd;

  // only the second stage of each synchroniser feeds logic
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      en_sync <= 2'h0;
      sel_sync <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      en_sync <= {en_sync[0], enable_pin_i};
      sel_sync <= {sel_sync[0], level_select_pin_i};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  always_comb
  begin
    en_ok = en_sync[1];
    scl_rise = scl_sync[1] && !scl_d;
    scl_fall = !scl_sync[1] && scl_d;
    start_seen = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
    stop_seen = scl_sync[1] && scl_d && !sda_d && sda_sync[1];
    status_value = 8'h00;
    status_value[good_bit] = en_ok && soft_start_done_i &&
      (sel_sync[1] ? level_high[enable_bit]
                   : level_low[enable_bit]);
    case (reg_ptr)
      reg_level_low: read_value = level_low;
      reg_level_high: read_value = level_high;
      reg_control: read_value = control & control_write_mask;
      reg_vendor: read_value = vendor_ident;
      reg_revision: read_value = revision_ident;
      reg_status: read_value = status_value;
      default: read_value = 8'h00;
    endcase
  end

  // written bytes queue here so register updates can lag the bus
  assign fifo_in_valid = (state == st_wdata) && scl_fall &&
    (bit_cnt == 3'h0) && en_ok;

  byte_fifo #(.width(data_width), .depth(fifo_depth)) u_byte_fifo (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .flush_i(!en_ok),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_ready),
    .in_data_i(shift),
    .out_valid_o(fifo_valid),
    .out_ready_i(1'b1),
    .out_data_o(fifo_out)
  );

  always_comb
  begin
    next_state = state;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_reg_ptr = reg_ptr;
    next_hs_mode = hs_mode;
    next_hs_pending = hs_pending;
    next_sda_oe = sda_oe_o;
    next_skip_fall = skip_fall;
    if (!en_ok || stop_seen)
    begin
      next_state = st_idle;
      next_sda_oe = 1'b0;
      next_hs_mode = 1'b0;
      next_hs_pending = 1'b0;
      next_skip_fall = 1'b0;
    end
    else if (start_seen)
    begin
      next_state = st_addr;
      next_bit_cnt = last_bit;
      next_sda_oe = 1'b0;
      next_skip_fall = 1'b1;
      if (hs_pending)
      begin
        next_hs_mode = 1'b1;
        next_hs_pending = 1'b0;
      end
    end
    else if (skip_fall && scl_fall)
      next_skip_fall = 1'b0; // the start's own scl fall carries no bit
    else
    begin
      if (scl_rise)
        next_shift = {shift[6:0], sda_sync[1]};
      case (state)
        st_idle, st_ignore:
          next_sda_oe = 1'b0;
        st_addr, st_reg, st_wdata:
          if (scl_fall && bit_cnt == 3'h0)
          begin
            next_state = state_t'(state + 1);
            if (state == st_addr)
            begin
              if (shift[7:1] == slave_addr)
                next_sda_oe = 1'b1;
              else
              begin
                next_sda_oe = 1'b0;
                next_state = st_ignore;
                if (shift[7:3] == master_code_top)
                  next_hs_pending = 1'b1;
              end
            end
            else if (state == st_reg)
            begin
              next_reg_ptr = shift;
              next_sda_oe = 1'b1;
            end
            else
              next_sda_oe = fifo_ready; // full queue answers nack
          end
          else if (scl_fall)
            next_bit_cnt = bit_cnt - 3'h1;
        st_addr_ack, st_reg_ack, st_wdata_ack:
          if (scl_fall)
          begin
            next_bit_cnt = last_bit;
            next_sda_oe = 1'b0;
            if (state == st_addr_ack && shift[1]) // ack bit sits below r/w
            begin
              next_state = st_rdata;
              next_sda_oe = !read_value[last_bit];
            end
            else if (state == st_addr_ack)
              next_state = st_reg;
            else
              next_state = st_wdata;
            if (state == st_wdata_ack)
              next_reg_ptr = reg_ptr + 8'h01;
          end
        st_rdata:
          if (scl_fall && bit_cnt == 3'h0)
          begin
            next_state = st_rdata_ack;
            next_sda_oe = 1'b0;
            next_reg_ptr = reg_ptr + 8'h01;
          end
          else if (scl_fall)
          begin
            next_bit_cnt = bit_cnt - 3'h1;
            next_sda_oe = !read_value[bit_cnt - 3'h1];
          end
        st_rdata_ack:
          if (scl_rise && sda_sync[1])
            next_state = st_ignore;
          else if (scl_fall)
          begin
            next_sda_oe = !read_value[last_bit];
            next_bit_cnt = last_bit;
            next_state = st_rdata;
          end
        default:
          next_state = st_idle;
      endcase
    end
  end

  // a fetch of the next read byte uses the bumped pointer after one cycle
  always_comb
  begin
    next_level_low = level_low;
    next_level_high = level_high;
    next_control = control;
    next_write_valid = 1'b0;
    next_write_data = write_data_o;
    if (!en_ok)
    begin
      next_level_low = level_low_default;
      next_level_high = level_high_default;
      next_control = control_default;
    end
    else if (fifo_valid)
    begin
      next_write_valid = 1'b1;
      next_write_data = fifo_out;
      case (write_ptr_q)
        reg_level_low: next_level_low = fifo_out;
        reg_level_high: next_level_high = fifo_out;
        reg_control:
          if (fifo_out[reset_bit])
          begin
            next_level_low = level_low_default;
            next_level_high = level_high_default;
            next_control = control_default;
          end
          else
            next_control = fifo_out & control_write_mask;
        default: ;
      endcase
    end
    next_setting = sel_sync[1] ? next_level_high : next_level_low;
  end

  // the queue holds data only; the target travels with each push
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i || !en_ok)
    begin
      pq_wr <= 4'h0;
      pq_rd <= 4'h0;
    end
    else
    begin
      if (fifo_in_valid && fifo_ready)
        pq_wr <= pq_wr + 4'h1;
      if (fifo_valid)
        pq_rd <= pq_rd + 4'h1;
    end
    if (fifo_in_valid && fifo_ready)
      ptr_queue[pq_wr] <= reg_ptr;
  end
  assign write_ptr_q = ptr_queue[pq_rd];

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      state <= st_idle;
      shift <= 8'h00;
      bit_cnt <= 3'h0;
      reg_ptr <= 8'h00;
      hs_mode <= 1'b0;
      hs_pending <= 1'b0;
      skip_fall <= 1'b0;
      sda_oe_o <= 1'b0;
      level_low <= level_low_default;
      level_high <= level_high_default;
      control <= control_default;
      active_setting_o <= level_low_default;
      discharge_enable_o <= 1'b0;
      slew_rate_o <= 3'h0;
      high_speed_o <= 1'b0;
      write_valid_o <= 1'b0;
      write_data_o <= 8'h00;
    end
    else
    begin
      state <= next_state;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      reg_ptr <= next_reg_ptr;
      hs_mode <= next_hs_mode;
      hs_pending <= next_hs_pending;
      skip_fall <= next_skip_fall;
      sda_oe_o <= next_sda_oe;
      level_low <= next_level_low;
      level_high <= next_level_high;
      control <= next_control;
      active_setting_o <= next_setting;
      discharge_enable_o <= next_control[7];
      slew_rate_o <= next_control[6:4];
      high_speed_o <= next_hs_mode;
      write_valid_o <= next_write_valid;
      write_data_o <= next_write_data;
    end
  end

  assign sda_o = 1'b0;

  chk_ack_needs_address: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (state == st_addr && next_state == st_addr_ack) |->
      shift[7:1] == slave_addr) else $error("ack to foreign address");
  chk_nack_master_code: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (state == st_ignore) |-> !sda_oe_o) else $error("sda pulled in ignore");
  chk_stop_idles: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (en_ok && stop_seen) |=> state == st_idle && !high_speed_o)
    else $error("stop did not idle");
  chk_disable_defaults: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    !en_ok |=> level_low == level_low_default && !sda_oe_o)
    else $error("registers not default");
  chk_reset_bit_zero: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    control[reset_bit] == 1'b0) else $error("reset bit stored");
  chk_sda_change_low: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    $changed(sda_oe_o) && en_ok |-> !scl_d || $past(start_seen || stop_seen))
    else $error("sda moved with scl high");
  chk_hs_entry: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    (en_ok && start_seen && hs_pending && !stop_seen) |=> ##1 high_speed_o)
    else $error("high speed not entered");
  chk_status_good: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    status_value[good_bit] |-> en_ok && soft_start_done_i)
    else $error("status good without enable");
endmodule

// ==== bench/i2c_master_model.sv ====
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic core_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  // scl rests high between frames; a released sda reads the pull-up
  initial
  begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // quarter scl period in core cycles; 6 gives a slow clock below 1 mhz
  int quarter = 2;
  task automatic q();
    repeat (quarter) @(negedge core_clk_i);
  endtask
  // serves as repeated start too: sda released while scl low first
  task automatic start();
    q();
    sda_pull_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_pull_o = 1'b1;
    q();
    scl_o = 1'b0;
  endtask
  task automatic stop();
    q();
    sda_pull_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_pull_o = 1'b0;
    q();
  endtask
  task automatic bit_io(input logic b, output logic s);
    q();
    sda_pull_o = !b;
    q();
    scl_o = 1'b1;
    q();
    s = sda_i;
    q();
    scl_o = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
    output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(ack_in, s);
    ack = !s;
  endtask
endmodule

// ==== bench/regulator_i2c_register_port_tb.sv ====
`timescale 1ns/1ps
module regulator_i2c_register_port_tb;
  import regport_pkg::*;
  localparam logic [7:0] vend_id = 8'h3c; // arbitrary value
  localparam logic [7:0] rev_id = 8'h07; // arbitrary value
  localparam logic [7:0] wr_addr = {slave_addr, 1'b0};
  localparam logic [7:0] rd_addr = {slave_addr, 1'b1};
  logic clk, rst_b, en, sel, ssd, scl, pull, sda_out, sda_oe, sda;
  logic disch, hs, wv;
  logic [2:0] slew;
  logic [7:0] setting, wd, last_wd;
  int n_wv = 0;
  int n_fail;
  int n_checks;
  assign sda = (pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  regulator_i2c_register_port #(
    .vendor_ident(vend_id),
    .revision_ident(rev_id)
  ) u_regulator_i2c_register_port (
    .core_clk_i(clk), .rst_b_i(rst_b), .enable_pin_i(en),
    .level_select_pin_i(sel), .soft_start_done_i(ssd), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_out), .sda_oe_o(sda_oe),
    .active_setting_o(setting), .discharge_enable_o(disch),
    .slew_rate_o(slew), .high_speed_o(hs), .write_valid_o(wv),
    .write_data_o(wd)
  );
  i2c_master_model m_master (
    .core_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull)
  );
  always @(posedge clk)
  begin
    if (wv === 1'b1)
    begin
      last_wd <= wd;
      n_wv <= n_wv + 1;
    end
  end
  task automatic check(input string what, input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic send(input logic [7:0] b, input logic want);
    logic [7:0] r;
    logic k;
    m_master.xfer(b, 1'b1, r, k);
    check("ack", {7'h00, k}, {7'h00, want});
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    m_master.start();
    send(wr_addr, 1'b1);
    send(a, 1'b1);
    send(d, 1'b1);
    m_master.stop();
  endtask
  task automatic rd_reg(input logic [7:0] a, exp);
    logic [7:0] r;
    logic k;
    m_master.start();
    send(wr_addr, 1'b1);
    send(a, 1'b1);
    m_master.start();
    send(rd_addr, 1'b1);
    m_master.xfer(8'hff, 1'b1, r, k);
    check("read", r, exp);
    m_master.stop();
    check("idle oe", {7'h00, sda_oe}, 8'h00);
  endtask
  task automatic t_defaults();
    logic [7:0] exp [7] = '{level_low_default, level_high_default,
      control_default, vend_id, rev_id, 8'h80, 8'h00};
    for (int i = 0; i < 7; i++)
      rd_reg(8'(i), exp[i]);
    check("sel high", setting, level_high_default);
    sel = 1'b0;
    wait_n(8);
    check("sel low", setting, level_low_default);
  endtask
  task automatic t_write();
    int n0;
    n0 = n_wv;
    wr_reg(reg_level_low, 8'h2a);
    check("wdata", last_wd, 8'h2a);
    check("wcount", 8'(n_wv - n0), 8'h01);
    check("low set", setting, 8'h2a);
    wr_reg(reg_level_high, 8'h55);
    sel = 1'b1;
    wait_n(8);
    check("high set", setting, 8'h55);
    rd_reg(reg_level_low, 8'h2a);
  endtask
  task automatic t_control();
    logic [7:0] r;
    logic k;
    wr_reg(reg_control, 8'hd0);
    check("discharge", {7'h00, disch}, 8'h01);
    check("slew", {5'h00, slew}, 8'h05);
    rd_reg(reg_control, 8'hd0);
    m_master.start();
    send(wr_addr, 1'b1);
    send(reg_vendor, 1'b1);
    m_master.xfer(8'h00, 1'b1, r, k);
    m_master.stop();
    rd_reg(reg_vendor, vend_id);
  endtask
  task automatic t_reset_bit();
    wr_reg(reg_control, 8'h04);
    rd_reg(reg_control, control_default);
    rd_reg(reg_level_low, level_low_default);
    rd_reg(reg_level_high, level_high_default);
  endtask
  task automatic t_foreign_and_hs();
    m_master.start();
    send(8'ha0, 1'b0);
    m_master.stop();
    m_master.quarter = 6;
    m_master.start();
    send(8'h09, 1'b0);
    m_master.quarter = 2;
    m_master.start();
    wait_n(8);
    check("hs on", {7'h00, hs}, 8'h01);
    send(wr_addr, 1'b1);
    send(reg_level_low, 1'b1);
    send(8'h11, 1'b1);
    m_master.start();
    send(wr_addr, 1'b1);
    send(reg_level_high, 1'b1);
    send(8'h22, 1'b1);
    check("hs held", {7'h00, hs}, 8'h01);
    m_master.stop();
    wait_n(8);
    check("hs off", {7'h00, hs}, 8'h00);
    rd_reg(reg_level_high, 8'h22);
  endtask
  task automatic t_enable_status();
    sel = 1'b0;
    en = 1'b0;
    wait_n(8);
    check("en low", setting, level_low_default);
    m_master.start();
    send(wr_addr, 1'b0);
    m_master.stop();
    en = 1'b1;
    wait_n(8);
    rd_reg(reg_level_low, level_low_default);
    sel = 1'b1;
    ssd = 1'b0;
    rd_reg(reg_status, 8'h00);
    check("sda_o", {7'h00, sda_out}, 8'h00);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  initial
  begin
    n_fail = 0;
    n_checks = 0;
    rst_b = 1'b0;
    en = 1'b1;
    sel = 1'b1;
    ssd = 1'b1;
    wait_n(8);
    rst_b = 1'b1;
    wait_n(8);
    t_defaults();
    t_write();
    t_control();
    t_reset_bit();
    t_foreign_and_hs();
    t_enable_status();
    tally_and_finish();
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    n_fail++;
    $display("Error at %0t: run did not finish", $time);
    tally_and_finish();
  end
endmodule
